/* hw/cir_defines.svh */
`ifndef CIR_DEFINES_SVH
`define CIR_DEFINES_SVH

////////////////////////////////////////////////////////////////////////////////
// clock
`define CIR_CLK_MHZ            50
`define CIR_CLK_KHZ            (`CIR_CLK_MHZ * 1000)
`define CIR_CLK_HZ             (`CIR_CLK_MHZ * 1000000)
`define CIR_NS2CYC(ns)         ((((ns) * `CIR_CLK_MHZ) + 999) / 1000)

////////////////////////////////////////////////////////////////////////////////
// register indices, byte address is four times the index
`define CIR_IDX_TXMOD          6'h01
`define CIR_IDX_CIRCFG         6'h02
`define CIR_IDX_LINK           6'h03
`define CIR_IDX_IDCTL          6'h04
`define CIR_IDX_PATH           6'h07
`define CIR_IDX_TXDATA         6'h08
`define CIR_IDX_BITTIME        6'h09

// reset values
`define CIR_RST_TXMOD          8'h69
`define CIR_RST_CIRCFG         8'h00
`define CIR_RST_LINK           8'h00
`define CIR_RST_IDCTL          8'h00
`define CIR_RST_PATH           8'h00
`define CIR_RST_BITTIME        8'h00

// field positions and write masks
`define CIR_IDCTL_FORCE_BIT    7
`define CIR_RLE_VALUE_BIT      7
`define CIR_CIRCFG_WMASK       8'hf7
`define CIR_PATH_WMASK         8'hb8

////////////////////////////////////////////////////////////////////////////////
// subcarrier frequency codes
`define CIR_FC_LO_A_FIRST      3
`define CIR_FC_LO_A_LAST       14
`define CIR_FC_LO_B_FIRST      26
`define CIR_FC_LO_B_LAST       29
`define CIR_FC_LO_TOP          30
`define CIR_LO_BASE_KHZ        27
`define CIR_LO_TOP_HZ          56900
`define CIR_FC_HI_A            5'h03
`define CIR_FC_HI_B            5'h08
`define CIR_FC_HI_C            5'h0b
`define CIR_HI_A_KHZ           400
`define CIR_HI_B_KHZ           450
`define CIR_HI_C_KHZ           480

// pulse width codes and times
`define CIR_PW_CODE_A          3'h2
`define CIR_PW_CODE_B          3'h3
`define CIR_PW_CODE_C          3'h4
`define CIR_PW_CODE_D          3'h5
`define CIR_PW_LO_A_NS         6000
`define CIR_PW_LO_B_NS         7000
`define CIR_PW_LO_C_NS         9000
`define CIR_PW_LO_D_NS         10600
`define CIR_PW_HI_A_NS         700
`define CIR_PW_HI_B_NS         800
`define CIR_PW_HI_C_NS         900

////////////////////////////////////////////////////////////////////////////////
// timing counts
`define CIR_US_CYC             `CIR_CLK_MHZ
`define CIR_FORCE_US           64
`define CIR_FORCE_CYC          (`CIR_FORCE_US * `CIR_CLK_MHZ)
`define CIR_BURST_EIGHT        4'h8
`define CIR_BURST_SIX          4'h6

`endif

/* hw/cir_pkg.sv */
package cir_pkg;

    typedef struct packed {
        logic [2:0] subcarrier_pulse_width_code;
        logic [4:0] subcarrier_freq_code;
    } cir_txmod_t;

    typedef enum logic [1:0] {
        continuous_pulse_mode,
        eight_pulse_mode,
        six_pulse_mode,
        reserved_pulse_mode
    } cir_mmode_t;

    typedef struct packed {
        logic       run_length_enable;
        logic       oversample_sel;
        logic       rx_high_range_sel;
        logic       demodulator_disable;
        logic       rsvd3;
        logic       tx_high_range_sel;
        logic [1:0] tx_modulation_mode;
    } cir_cfg_t;

    typedef struct packed {
        logic       forced_tx_pulse;
        logic [2:0] slow_mode_xcvr_cfg;
        logic       xcvr_ident_bit3;
        logic [1:0] xcvr_idctl_bits_hi;
        logic       xcvr_idctl_bit0;
    } cir_idctl_t;

    typedef struct packed {
        logic       auto_xcvr_config;
        logic       rsvd6;
        logic       cfg_pin0_dir;
        logic       rx_invert;
        logic       cfg_pins_hi_dir;
        logic [2:0] rsvd;
    } cir_path_t;

    typedef enum logic [1:0] {
        cir_mode_sir,
        cir_mode_hdx,
        cir_mode_consumer,
        cir_mode_other
    } cir_ir_mode_t;

    typedef struct packed {
        logic [1:0] cfg_pins_hi;
        logic       cfg_pin0;
    } cir_pins_t;

    typedef enum logic {
        tx_idle,
        tx_run
    } cir_tx_state_t;

    typedef struct packed {
        logic [10:0] phase;
    } cir_pg_state_t;

    typedef struct packed {
        logic [31:0]   hrdata;
        logic          hreadyout;
        logic          hresp;
        logic          wr_pend;
        logic [5:0]    wr_idx;
        cir_txmod_t    txmod;
        cir_cfg_t      circfg;
        logic [7:0]    link;
        cir_idctl_t    idctl;
        cir_path_t     path;
        logic [7:0]    bittime;
        logic [11:0]   force_cnt;
        cir_tx_state_t tx_state;
        logic          tx_rle;
        logic [7:0]    txbyte;
        logic [7:0]    shreg;
        logic [7:0]    bits_left;
        logic [5:0]    us_cnt;
        logic [7:0]    bit_us;
        logic          line_bit;
        logic [3:0]    burst_cnt;
        logic [3:0]    sync1;
        logic [3:0]    sync2;
        cir_pins_t     pin_o;
        cir_pins_t     pin_oe;
        logic          tx_out;
    } cir_state_t;

endpackage

/* hw/cir_pulse_gen.sv */
`timescale 1ns/1ps

module cir_pulse_gen (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        ce,
    input  wire logic        run,
    input  wire logic [10:0] period,
    input  wire logic [10:0] width,
    output logic             level,
    output logic             pulse_end
);

    cir_pkg::cir_pg_state_t s;
    cir_pkg::cir_pg_state_t n;

    ////////////////////////////////////////////////////////////////////////////
    // phase restarts at zero whenever the run drops, so a burst always
    // opens with a full pulse
    always_comb begin
        n = s;
        if (!run || (s.phase == period - 11'h001)) begin
            n.phase = 11'h000;
        end else begin
            n.phase = s.phase + 11'h001;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
        end else if (ce) begin
            s <= n;
        end
    end

    // high part of the subcarrier period, and its last cycle
    assign level     = run && (s.phase < width);
    assign pulse_end = run && (s.phase == width - 11'h001);

endmodule

/* hw/cir_cfg.sv */
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/1ps
`include "cir_defines.svh"

// Overview of operation
// RQ1: frequency code selects subcarrier per range table
// RQ2: pulse width code selects width; others reserved
// RQ3: consumer config register resets to zero
// RQ4: mode 00 pulses throughout each zero bit
// RQ5: mode 01 sends eight pulses per zero run
// RQ6: mode 10 sends six pulses per zero run
// RQ7: software never programs mode 11
// RQ8: bit 2 picks transmit range and table column
// RQ9: bit 4 bypasses internal demodulator
// RQ10: software sets bypass for external demodulation, oversampling
// RQ11: bit 5 picks receive demodulator range
// RQ12: bit 6 selects oversampling receive mode
// RQ13: bit 7 enables run length byte coding
// RQ14: pin0 input: bit0 reads pin, writes ignored
// RQ15: pin0 output: bit0 drives pin per auto mode
// RQ16: bits 2-1 likewise for pins 2 and 1
// RQ17: bit 3 reads ident pin, writes ignored
// RQ18: bits 6-4 drive pins in auto slow mode
// RQ19: writing one forces transmit high for 64 us
// RQ20: writing zero leaves forced bit and timer
// RQ21: software avoids holding transmit high repeatedly
// RQ22: offset 3 maps link control and bank select
// RQ23: freq code bits 4-0, width bits 7-5
// RQ24: auto config lets modes drive pins
// RQ25: direction bits set pin0 and pins 2-1
// RQ26: forced pulse timer counts clocks, never short

module cir_cfg (
    input  wire logic                    hclk,
    input  wire logic                    hresetn,
    input  wire logic                    ce,
    input  wire logic                    hsel,
    input  wire logic [7:0]              haddr,
    input  wire logic [1:0]              htrans,
    input  wire logic                    hwrite,
    input  wire logic [2:0]              hsize,
    input  wire logic                    hready,
    input  wire logic [31:0]             hwdata,
    output logic                         hreadyout,
    output logic                         hresp,
    output logic [31:0]                  hrdata,
    input  wire cir_pkg::cir_ir_mode_t   ir_mode,
    input  wire cir_pkg::cir_pins_t      cfg_pins_in,
    input  wire logic                    ident_pin3,
    output cir_pkg::cir_pins_t           cfg_pins_out,
    output cir_pkg::cir_pins_t           cfg_pins_oe,
    output logic                         ir_transmit_out,
    output cir_pkg::cir_cfg_t            rx_cfg,
    output logic [7:0]                   link_ctl
);

    ////////////////////////////////////////////////////////////////////////////
    // subcarrier period table for the low range, built at elaboration
    function automatic logic [351:0] cir_lo_tab();
        logic [351:0] t;
        t = '0;
        for (int i = 0; i < 32; i++) begin
            if ((i >= `CIR_FC_LO_A_FIRST && i <= `CIR_FC_LO_A_LAST) ||
                (i >= `CIR_FC_LO_B_FIRST && i <= `CIR_FC_LO_B_LAST)) begin
                t[i*11 +: 11] = 11'(`CIR_CLK_KHZ / (i + `CIR_LO_BASE_KHZ)); // [RQ1]
            end
        end
        t[`CIR_FC_LO_TOP*11 +: 11] = 11'(`CIR_CLK_HZ / `CIR_LO_TOP_HZ);
        return t;
    endfunction

    localparam logic [351:0] LO_PERIOD  = cir_lo_tab();
    localparam logic [11:0]  FORCE_LAST = 12'(`CIR_FORCE_CYC - 1);
    localparam logic [5:0]   US_LAST    = 6'(`CIR_US_CYC - 1);

    // {valid, period in cycles}; reserved codes give no carrier
    function automatic logic [11:0] cir_period(logic [4:0] code, logic hi);
        logic [11:0] r;
        r = '0;
        if (!hi) begin
            if (LO_PERIOD[32'(code)*11 +: 11] != 11'h000) begin
                r = {1'b1, LO_PERIOD[32'(code)*11 +: 11]}; // [RQ1] [RQ8]
            end
        end else begin
            case (code)
                `CIR_FC_HI_A: r = {1'b1, 11'(`CIR_CLK_KHZ / `CIR_HI_A_KHZ)}; // [RQ1]
                `CIR_FC_HI_B: r = {1'b1, 11'(`CIR_CLK_KHZ / `CIR_HI_B_KHZ)};
                `CIR_FC_HI_C: r = {1'b1, 11'(`CIR_CLK_KHZ / `CIR_HI_C_KHZ)};
                default:      r = '0;
            endcase
        end
        return r;
    endfunction

    // {valid, pulse width in cycles}
    function automatic logic [11:0] cir_width(logic [2:0] code, logic hi);
        logic [11:0] r;
        r = '0;
        case ({hi, code})
            {1'b0, `CIR_PW_CODE_A}: r = {1'b1, 11'(`CIR_NS2CYC(`CIR_PW_LO_A_NS))}; // [RQ2] [RQ8]
            {1'b0, `CIR_PW_CODE_B}: r = {1'b1, 11'(`CIR_NS2CYC(`CIR_PW_LO_B_NS))};
            {1'b0, `CIR_PW_CODE_C}: r = {1'b1, 11'(`CIR_NS2CYC(`CIR_PW_LO_C_NS))};
            {1'b0, `CIR_PW_CODE_D}: r = {1'b1, 11'(`CIR_NS2CYC(`CIR_PW_LO_D_NS))};
            {1'b1, `CIR_PW_CODE_A}: r = {1'b1, 11'(`CIR_NS2CYC(`CIR_PW_HI_A_NS))};
            {1'b1, `CIR_PW_CODE_B}: r = {1'b1, 11'(`CIR_NS2CYC(`CIR_PW_HI_B_NS))};
            {1'b1, `CIR_PW_CODE_C}: r = {1'b1, 11'(`CIR_NS2CYC(`CIR_PW_HI_C_NS))};
            default:                r = '0;
        endcase
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    cir_pkg::cir_state_t s;
    cir_pkg::cir_state_t n;

    logic [11:0] car_per;
    logic [11:0] car_wid;
    logic        car_run;
    logic        car_level;
    logic        car_end;

    // carrier runs only during zero bits and only for a legal code pair
    assign car_per = cir_period(s.txmod.subcarrier_freq_code, s.circfg.tx_high_range_sel); // [RQ23]
    assign car_wid = cir_width(s.txmod.subcarrier_pulse_width_code, s.circfg.tx_high_range_sel);
    assign car_run = !s.line_bit && car_per[11] && car_wid[11];

    cir_pulse_gen u_pulse (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .ce        (ce),
        .run       (car_run),
        .period    (car_per[10:0]),
        .width     (car_wid[10:0]),
        .level     (car_level),
        .pulse_end (car_end)
    );

    ////////////////////////////////////////////////////////////////////////////
    // next state: bus, registers, forced pulse, transmit engine, pins
    always_comb begin
        logic                gate;
        logic                addr_ok;
        logic [5:0]          ridx;
        logic [2:0]          drive;
        cir_pkg::cir_mmode_t mode;
        gate    = 1'b0;
        addr_ok = 1'b0;
        ridx    = haddr[7:2];
        drive   = 3'h0;
        mode    = cir_pkg::cir_mmode_t'(s.circfg.tx_modulation_mode);
        n       = s;

        n.hreadyout = 1'b1;
        n.hresp     = 1'b0;

        // pin synchronisers, first stage feeds only the second
        n.sync1 = {ident_pin3, cfg_pins_in};
        n.sync2 = s.sync1;

        // forced pulse timer expiry, before the write so a new set wins
        if (s.idctl.forced_tx_pulse) begin
            if (s.force_cnt == 12'h000) begin
                n.idctl.forced_tx_pulse = 1'b0; // [RQ19]
            end else begin
                n.force_cnt = s.force_cnt - 12'h001; // [RQ26]
            end
        end

        // bit timer: one microsecond prescale, bittime+1 microseconds per bit
        if (s.tx_state == cir_pkg::tx_run) begin
            if (s.us_cnt == US_LAST) begin
                n.us_cnt = 6'h00;
                if (s.bit_us == s.bittime) begin
                    n.bit_us = 8'h00;
                    if (s.bits_left == 8'h00) begin
                        n.tx_state = cir_pkg::tx_idle;
                        n.line_bit = 1'b1;
                    end else begin
                        n.bits_left = s.bits_left - 8'h01;
                        if (!s.tx_rle) begin
                            n.shreg    = {1'b0, s.shreg[7:1]};
                            n.line_bit = s.shreg[1];
                        end
                    end
                end else begin
                    n.bit_us = s.bit_us + 8'h01;
                end
            end else begin
                n.us_cnt = s.us_cnt + 6'h01;
            end
        end

        // data phase of a write
        if (s.wr_pend) begin
            case (s.wr_idx)
                `CIR_IDX_TXMOD:   n.txmod = hwdata[7:0];
                `CIR_IDX_CIRCFG:  n.circfg = hwdata[7:0] & `CIR_CIRCFG_WMASK; // [RQ9] [RQ11] [RQ12]
                `CIR_IDX_LINK:    n.link = hwdata[7:0]; // [RQ22]
                `CIR_IDX_PATH:    n.path = hwdata[7:0] & `CIR_PATH_WMASK; // [RQ25]
                `CIR_IDX_BITTIME: n.bittime = hwdata[7:0];
                `CIR_IDX_IDCTL: begin
                    if (s.path.cfg_pin0_dir) begin
                        n.idctl.xcvr_idctl_bit0 = hwdata[0]; // [RQ14]
                    end
                    if (s.path.cfg_pins_hi_dir) begin
                        n.idctl.xcvr_idctl_bits_hi = hwdata[2:1]; // [RQ16]
                    end
                    n.idctl.slow_mode_xcvr_cfg = hwdata[6:4];
                    // a zero here leaves bit and timer alone
                    if (hwdata[`CIR_IDCTL_FORCE_BIT]) begin // [RQ20]
                        n.idctl.forced_tx_pulse = 1'b1; // [RQ19]
                        n.force_cnt             = FORCE_LAST;
                    end
                end
                `CIR_IDX_TXDATA: begin
                    // a byte written while busy is dropped
                    if (s.tx_state == cir_pkg::tx_idle) begin
                        n.tx_state = cir_pkg::tx_run;
                        n.txbyte   = hwdata[7:0];
                        n.tx_rle   = s.circfg.run_length_enable;
                        n.us_cnt   = 6'h00;
                        n.bit_us   = 8'h00;
                        if (s.circfg.run_length_enable) begin
                            n.line_bit  = hwdata[`CIR_RLE_VALUE_BIT]; // [RQ13]
                            n.bits_left = {1'b0, hwdata[6:0]};
                        end else begin
                            n.shreg     = hwdata[7:0];
                            n.line_bit  = hwdata[0];
                            n.bits_left = 8'h07;
                        end
                    end
                end
                default: ;
            endcase
        end

        // burst counter clears on every one bit, caps at eight
        if (s.line_bit) begin
            n.burst_cnt = 4'h0;
        end else if (car_end && (s.burst_cnt < `CIR_BURST_EIGHT)) begin
            n.burst_cnt = s.burst_cnt + 4'h1;
        end

        // modulation gate per mode; the reserved mode stays dark
        unique case (mode)
            cir_pkg::continuous_pulse_mode: gate = 1'b1; // [RQ4]
            cir_pkg::eight_pulse_mode:      gate = s.burst_cnt < `CIR_BURST_EIGHT; // [RQ5]
            cir_pkg::six_pulse_mode:        gate = s.burst_cnt < `CIR_BURST_SIX; // [RQ6]
            cir_pkg::reserved_pulse_mode:   gate = 1'b0; // [RQ7]
        endcase
        n.tx_out = n.idctl.forced_tx_pulse || (car_run && gate && car_level); // [RQ19]

        // pin drive: manual, or mode-dependent under automatic config
        if (!n.path.auto_xcvr_config || (ir_mode == cir_pkg::cir_mode_hdx)) begin
            drive = {n.idctl.xcvr_idctl_bits_hi, n.idctl.xcvr_idctl_bit0}; // [RQ15] [RQ16]
        end else if (ir_mode == cir_pkg::cir_mode_sir) begin
            drive = n.idctl.slow_mode_xcvr_cfg; // [RQ18] [RQ24]
        end
        n.pin_o  = drive;
        n.pin_oe = {n.path.cfg_pins_hi_dir, n.path.cfg_pins_hi_dir, n.path.cfg_pin0_dir}; // [RQ25]

        // address phase: decode and latch, read data from the updated state
        addr_ok   = hsel && htrans[1] && hready;
        n.wr_pend = addr_ok && hwrite;
        n.wr_idx  = ridx;
        if (addr_ok && !hwrite) begin
            case (ridx)
                `CIR_IDX_TXMOD:   n.hrdata = {24'h000000, n.txmod};
                `CIR_IDX_CIRCFG:  n.hrdata = {24'h000000, n.circfg};
                `CIR_IDX_LINK:    n.hrdata = {24'h000000, n.link}; // [RQ22]
                `CIR_IDX_PATH:    n.hrdata = {24'h000000, n.path};
                `CIR_IDX_BITTIME: n.hrdata = {24'h000000, n.bittime};
                `CIR_IDX_TXDATA:  n.hrdata = {23'h000000, (n.tx_state == cir_pkg::tx_run), n.txbyte};
                `CIR_IDX_IDCTL: begin
                    n.hrdata = {24'h000000,
                                n.idctl.forced_tx_pulse,
                                n.idctl.slow_mode_xcvr_cfg, // [RQ18]
                                n.sync2[3], // [RQ17]
                                n.path.cfg_pins_hi_dir ? n.idctl.xcvr_idctl_bits_hi : n.sync2[2:1], // [RQ16]
                                n.path.cfg_pin0_dir ? n.idctl.xcvr_idctl_bit0 : n.sync2[0]}; // [RQ14] [RQ15]
                end
                default:          n.hrdata = 32'h00000000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // whole state freezes while ce is low
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s           <= '0;
            s.hreadyout <= 1'b1;
            s.txmod     <= `CIR_RST_TXMOD;
            s.circfg    <= `CIR_RST_CIRCFG; // [RQ3]
            s.link      <= `CIR_RST_LINK;
            s.idctl     <= `CIR_RST_IDCTL;
            s.path      <= `CIR_RST_PATH;
            s.bittime   <= `CIR_RST_BITTIME;
            s.line_bit  <= 1'b1;
        end else if (ce) begin
            s <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // every output straight from the state register
    assign hreadyout       = s.hreadyout;
    assign hresp           = s.hresp;
    assign hrdata          = s.hrdata;
    assign cfg_pins_out    = s.pin_o;
    assign cfg_pins_oe     = s.pin_oe;
    assign ir_transmit_out = s.tx_out;
    assign rx_cfg          = s.circfg; // [RQ9] [RQ11] [RQ12] [RQ13]
    assign link_ctl        = s.link;

endmodule

/* verif/cir_cfg_monitor.sv */
`timescale 1ns/1ps
module cir_cfg_monitor (
    input logic               hclk,
    input logic               hresetn,
    input logic               hsel,
    input logic [7:0]         haddr,
    input logic [1:0]         htrans,
    input logic               hwrite,
    input logic               hready,
    input logic [31:0]        hwdata,
    input cir_pkg::cir_cfg_t  rx_cfg,
    input logic [7:0]         link_ctl,
    input cir_pkg::cir_pins_t cfg_pins_oe,
    input logic               ir_transmit_out
);
    localparam int max_hi = 3200;
    logic        wr_ph;
    logic [5:0]  wr_idx;
    logic [31:0] wd_q;
    logic [11:0] hi_cnt;
////////////////////////////////////////
    // write address phase, judged one edge later at its data edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ph <= 1'b0;
            wr_idx <= 6'h00;
            wd_q <= 32'h0;
        end else begin
            wr_ph <= hsel & htrans[1] & hready & hwrite;
            wr_idx <= haddr[7:2];
            wd_q <= hwdata;
        end
    end
    // high stretch length, saturating so a stuck line cannot wrap
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hi_cnt <= 12'h000;
        end else if (!ir_transmit_out) begin
            hi_cnt <= 12'h000;
        end else if (hi_cnt != 12'hfff) begin
            hi_cnt <= hi_cnt + 12'h001;
        end
    end
////////////////////////////////////////
    default clocking mcb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    cfg_write_a: assert property (wr_ph && wr_idx == 6'h02 |=> {24'h0, rx_cfg} == (wd_q & 32'hf7))
        else $error("config copy wrong after write");
    cfg_hold_a: assert property (!(wr_ph && wr_idx == 6'h02) |=> $stable(rx_cfg))
        else $error("config copy moved without write");
    link_write_a: assert property (wr_ph && wr_idx == 6'h03 |=> link_ctl == wd_q[7:0])
        else $error("link byte wrong after write");
    pin_dir_a: assert property (wr_ph && wr_idx == 6'h07 |=> cfg_pins_oe == {wd_q[3], wd_q[3], wd_q[5]})
        else $error("pin enables do not follow direction bits");
    oe_hold_a: assert property (!(wr_ph && wr_idx == 6'h07) |=> $stable(cfg_pins_oe))
        else $error("pin enables moved without write");
    force_rise_a: assert property (wr_ph && wr_idx == 6'h04 && hwdata[7] |=> ir_transmit_out [*8])
        else $error("forced pulse not raised");
    force_len_a: assert property (hi_cnt <= max_hi)
        else $error("emitter held high too long");
    reset_clear_a: assert property ($rose(hresetn) |-> rx_cfg == 8'h00 && link_ctl == 8'h00 && !ir_transmit_out)
        else $error("outputs not clear after reset");
endmodule
bind cir_cfg cir_cfg_monitor mon_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .rx_cfg(rx_cfg),
    .link_ctl(link_ctl), .cfg_pins_oe(cfg_pins_oe), .ir_transmit_out(ir_transmit_out));

/* verif/cir_xcvr_model.sv */
`timescale 1ns/1ps
module cir_xcvr_model (
    input cir_pkg::cir_pins_t  pins_out,
    input cir_pkg::cir_pins_t  pins_oe,
    input logic [3:0]          id_val,
    output cir_pkg::cir_pins_t pins_lvl,
    output logic               ident_lvl
);
    // the block's drive wins; released lines carry the adapter id code
    assign pins_lvl = (pins_out & pins_oe) | (id_val[2:0] & ~pins_oe);
    // fourth id line is input only
    assign ident_lvl = id_val[3];
endmodule

/* verif/tb.sv */
`timescale 1ns/1ps
module tb;
    logic                  hclk = 1'b0;
    logic                  hresetn = 1'b0;
    logic                  hsel = 1'b0;
    logic [7:0]            haddr = 8'h00;
    logic [1:0]            htrans = 2'h0;
    logic                  hwrite = 1'b0;
    logic [31:0]           hwdata = 32'h0;
    logic [31:0]           hrdata, q;
    logic                  hreadyout, hresp, ir_transmit_out, ident;
    logic [7:0]            link_ctl;
    logic [3:0]            id_val = 4'ha;
    cir_pkg::cir_ir_mode_t ir_mode = cir_pkg::cir_mode_hdx;
    cir_pkg::cir_pins_t    pins_lvl, pins_out, pins_oe;
    cir_pkg::cir_cfg_t     rx_cfg;
    int                    bad_count = 0, total_checks = 0;
    int                    cyc = 0, n;
    int                    rises = 0;
    int                    exp_pulses [3] = '{1, 8, 6};
    // 20 ns period, 64 us forced pulse
    localparam int         force_cyc = 64000 / 20;

    always #10 hclk = ~hclk;

    cir_cfg dut_u (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .ir_mode(ir_mode), .cfg_pins_in(pins_lvl), .ident_pin3(ident),
        .cfg_pins_out(pins_out), .cfg_pins_oe(pins_oe), .ir_transmit_out(ir_transmit_out),
        .rx_cfg(rx_cfg), .link_ctl(link_ctl));
    cir_xcvr_model xcvr_u (.pins_out(pins_out), .pins_oe(pins_oe), .id_val(id_val),
        .pins_lvl(pins_lvl), .ident_lvl(ident));
////////////////////////////////////////
    task results;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one single transfer; read data lands in q
    task bus(input logic wr, input logic [5:0] idx, input logic [7:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {idx, 2'b00};
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
        #1;
    endtask
    task tick;
        @(posedge hclk);
        #1;
    endtask
    task hold_len;
        n = 0;
        while (ir_transmit_out === 1'b1) begin
            tick;
            n++;
        end
    endtask
////////////////////////////////////////
    // hang guard, well above the expected run
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 40000) begin
            bad_count++;
            results;
        end
    end
    // pulses seen on the emitter
    always @(posedge ir_transmit_out) rises++;

    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, 6'h02, 8'h00);
        check(q, 32'h0);
        bus(1'b0, 6'h01, 8'h00);
        check(q, 32'h69);
        bus(1'b1, 6'h04, 8'h05);
        bus(1'b0, 6'h04, 8'h00);
        check(q, {28'h0, id_val});
        // mode 10, demodulator off for oversampling; bit 3 stays clear
        bus(1'b1, 6'h02, 8'hfe);
        bus(1'b0, 6'h02, 8'h00);
        check(q, 32'hf6);
        check({24'h0, rx_cfg}, 32'hf6);
        bus(1'b1, 6'h03, 8'ha5);
        bus(1'b0, 6'h03, 8'h00);
        check(q, 32'ha5);
        // manual drive with all pins as outputs
        bus(1'b1, 6'h07, 8'h28);
        check({29'h0, pins_oe}, 32'h7);
        bus(1'b1, 6'h04, 8'h05);
        tick;
        check({29'h0, pins_out}, 32'h5);
        bus(1'b0, 6'h04, 8'h00);
        check(q, 32'h0d);
        // auto config: slow mode takes bits 6-4, hdx mode bits 2-0, consumer mode drives zero
        @(posedge hclk);
        ir_mode <= cir_pkg::cir_mode_sir;
        bus(1'b1, 6'h07, 8'ha8);
        bus(1'b1, 6'h04, 8'h32);
        tick;
        check({29'h0, pins_out}, 32'h3);
        @(posedge hclk);
        ir_mode <= cir_pkg::cir_mode_hdx;
        repeat (2) tick;
        check({29'h0, pins_out}, 32'h2);
        @(posedge hclk);
        ir_mode <= cir_pkg::cir_mode_consumer;
        repeat (2) tick;
        check({29'h0, pins_out}, 32'h0);
        // forced pulse, rewritten once only to spare the emitter
        bus(1'b1, 6'h04, 8'h80);
        bus(1'b1, 6'h04, 8'h00);
        bus(1'b0, 6'h04, 8'h00);
        check({31'h0, q[7]}, 32'h1);
        hold_len;
        bus(1'b1, 6'h04, 8'h80);
        hold_len;
        check(n, force_cyc);
        bus(1'b0, 6'h04, 8'h00);
        check({31'h0, q[7]}, 32'h0);
        // one zero bit of 32 us, run-length coded, 400 kHz carrier
        bus(1'b1, 6'h09, 8'h1f);
        bus(1'b1, 6'h01, 8'h63);
        for (int k = 0; k < 3; k++) begin
            bus(1'b1, 6'h02, 8'h84 | 8'(k));
            rises = 0;
            bus(1'b1, 6'h08, 8'h00);
            do bus(1'b0, 6'h08, 8'h00); while (q[8] === 1'b1);
            check(k == 0 ? 32'(rises > 10) : rises, exp_pulses[k]);
        end
        bus(1'b0, 6'h3f, 8'h00);
        check(q, 32'h0);
        check({31'h0, hresp}, 32'h0);
        results;
    end
endmodule
